/* core/esrp_stack_ctx.sv */
`timescale 1ns/10ps
`default_nettype none
module esrp_stack_ctx #(
	parameter bit SEC_PRESENT = 1'b1
) (
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// Core requests, held until the matching done pulse
	input  wire logic        entry_req,
	input  wire logic        frame_secure,
	input  wire logic        callee_skip,
	input  wire logic        thread_mode,
	input  wire logic        stack_select_control_bit,
	input  wire logic        handler_secure,
	input  wire logic        return_req,
	input  wire logic [31:0] branch_target,
	input  wire logic        fp_first_insn,
	input  wire logic [31:0] sp_in,
	// Core register bank
	output logic      [4:0]  ctx_idx,
	input  wire logic [31:0] ctx_rdata,
	output logic             ctx_wr,
	output logic      [31:0] ctx_wdata,
	// Core results
	output logic             sp_wr,
	output logic      [31:0] sp_wdata,
	output logic      [31:0] link_register,
	output logic             link_wr,
	output logic             saved_stack_select_clear,
	output logic             saved_stack_select_restore_wr,
	output logic             saved_stack_select,
	output logic             entry_done,
	output logic             return_done,
	output logic             return_matched,
	output logic             lazy_done,
	// Stack memory master
	output logic             mem_req,
	output logic             mem_we,
	output logic      [31:0] mem_addr,
	output logic      [31:0] mem_wdata,
	input  wire logic        mem_ack,
	input  wire logic [31:0] mem_rdata,
	// AXI4-Lite slave
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic      [1:0]  s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [11:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic      [31:0] s_axi_rdata,
	output logic      [1:0]  s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);

	typedef struct packed {
		esrp_pkg::esrp_state_t state;
		logic [4:0]  slot;
		logic [4:0]  last_slot;
		logic [31:0] base;
		logic        align_pad;
		logic        ext;
		logic        lazy_op;
		logic        lazy_pending;
		logic [31:0] lazy_base;
		logic        ret_saved_stack_select;
		logic [31:0] payload;
		logic [1:0]  ctrl;
		logic        mem_req;
		logic        mem_we;
		logic [31:0] mem_addr;
		logic [31:0] mem_wdata;
		logic [4:0]  ctx_idx;
		logic        ctx_wr;
		logic [31:0] ctx_wdata;
		logic        sp_wr;
		logic [31:0] sp_wdata;
		logic        link_wr;
		logic        saved_stack_select_clear;
		logic        saved_stack_select_restore_wr;
		logic        saved_saved_stack_select;
		logic        entry_done;
		logic        return_done;
		logic        return_matched;
		logic        lazy_done;
		logic        aw_got;
		logic        w_got;
		logic [11:0] awaddr;
		logic [31:0] wdata;
		logic        wstrb0;
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [1:0]  rresp;
		logic [31:0] rdata;
	} esrp_ctx_t;

	esrp_ctx_t q_reg;
	esrp_ctx_t q_next;

	logic [31:0] entry_payload;
	logic        target_is_payload;
	logic        fp_enable;
	logic        fp_lazy;
	logic [31:0] raw_base;
	logic        pad_now;

	assign fp_enable = q_reg.ctrl[esrp_pkg::CTRL_FP_EN];
	assign fp_lazy   = q_reg.ctrl[esrp_pkg::CTRL_LAZY];

	esrp_payload_fmt #(
		.SEC_PRESENT(SEC_PRESENT)
	) u_fmt (
		.frame_secure            (frame_secure),
		.callee_skip             (callee_skip),
		.ext_frame               (fp_enable),
		.thread_mode             (thread_mode),
		.stack_select_control_bit(stack_select_control_bit),
		.handler_secure          (handler_secure),
		.branch_target           (branch_target),
		.payload                 (entry_payload),
		.target_is_payload       (target_is_payload)
	);

	function automatic logic [31:0] frame_bytes(input logic ext);
		frame_bytes = ext ? esrp_pkg::EXT_BYTES : esrp_pkg::BASIC_BYTES;
	endfunction

	function automatic logic [31:0] slot_addr(input logic [31:0] base, input logic [4:0] slot);
		slot_addr = base + {25'h0000000, slot, 2'h0};
	endfunction

	function automatic logic [31:0] read_reg(input esrp_ctx_t q, input logic [11:0] a);
		unique case (a)
			esrp_pkg::OFS_CTRL:    read_reg = {30'h00000000, q.ctrl};
			esrp_pkg::OFS_STATUS:  read_reg = {28'h0000000, q.lazy_pending, q.ext, q.state};
			esrp_pkg::OFS_PAYLOAD: read_reg = q.payload;
			esrp_pkg::OFS_FRAME:   read_reg = q.base;
			default:               read_reg = 32'h00000000;
		endcase
	endfunction

	function automatic logic reg_mapped(input logic [11:0] a);
		reg_mapped = (a == esrp_pkg::OFS_CTRL) || (a == esrp_pkg::OFS_STATUS) ||
			(a == esrp_pkg::OFS_PAYLOAD) || (a == esrp_pkg::OFS_FRAME);
	endfunction

	// Lower SP by frame size, then round down to a doubleword
	assign raw_base = sp_in - frame_bytes(fp_enable);
	assign pad_now  = (q_reg.slot == esrp_pkg::SLOT_STATUS) ?
		mem_rdata[esrp_pkg::STATUS_PAD_BIT] : q_reg.align_pad;

	always_comb
	begin
		q_next = q_reg;
		q_next.ctx_wr           = 1'b0;
		q_next.sp_wr            = 1'b0;
		q_next.link_wr          = 1'b0;
		q_next.saved_stack_select_clear      = 1'b0;
		q_next.saved_stack_select_restore_wr = 1'b0;
		q_next.entry_done       = 1'b0;
		q_next.return_done      = 1'b0;
		q_next.lazy_done        = 1'b0;

		unique case (q_reg.state)
			esrp_pkg::ST_IDLE:
			begin
				if (q_reg.lazy_pending && (fp_first_insn || entry_req))
				begin
					// Deferred fp save before any fp use or nesting
					q_next.state     = esrp_pkg::ST_PUSH;
					q_next.lazy_op   = 1'b1;
					q_next.base      = q_reg.lazy_base;
					q_next.slot      = esrp_pkg::SLOT_FP_FIRST;
					q_next.ctx_idx   = esrp_pkg::SLOT_FP_FIRST;
					q_next.last_slot = esrp_pkg::SLOT_FP_STATUS_CONTROL_WORD;
				end
				else if (entry_req && !q_reg.entry_done)
				begin
					// Frame goes on the stack selected right now
					q_next.state       = esrp_pkg::ST_PUSH;
					q_next.lazy_op     = 1'b0;
					q_next.ext         = fp_enable;
					q_next.base        = raw_base & esrp_pkg::DWORD_MASK;
					q_next.align_pad   = raw_base[2];
					q_next.slot        = esrp_pkg::SLOT_FIRST;
					q_next.ctx_idx     = esrp_pkg::SLOT_FIRST;
					if (fp_enable && !fp_lazy)
					begin
						q_next.last_slot = esrp_pkg::SLOT_FP_STATUS_CONTROL_WORD;
					end
					else
					begin
						q_next.last_slot = esrp_pkg::SLOT_STATUS;
					end
					q_next.payload     = entry_payload;
					q_next.saved_saved_stack_select = stack_select_control_bit;
				end
				else if (return_req && !q_reg.return_done)
				begin
					if (target_is_payload)
					begin
						// Return request: unstack from the selected stack
						q_next.state          = esrp_pkg::ST_POP;
						q_next.base           = sp_in;
						q_next.slot           = esrp_pkg::SLOT_FIRST;
						q_next.ctx_idx        = esrp_pkg::SLOT_FIRST;
						q_next.ext            = ~branch_target[esrp_pkg::PAY_FRAME_FMT];
						q_next.ret_saved_stack_select      = branch_target[esrp_pkg::PAY_SAVED_STACK_SELECT];
						q_next.return_matched = (branch_target == q_reg.payload);
						if (!branch_target[esrp_pkg::PAY_FRAME_FMT] && !q_reg.lazy_pending)
						begin
							q_next.last_slot = esrp_pkg::SLOT_FP_STATUS_CONTROL_WORD;
						end
						else
						begin
							q_next.last_slot = esrp_pkg::SLOT_STATUS;
						end
					end
					else
					begin
						// Ordinary branch, nothing to unstack
						q_next.return_done    = 1'b1;
						q_next.return_matched = 1'b0;
					end
				end
			end
			esrp_pkg::ST_PUSH:
			begin
				if (!q_reg.mem_req)
				begin
					q_next.mem_req  = 1'b1;
					q_next.mem_we   = 1'b1;
					q_next.mem_addr = slot_addr(q_reg.base, q_reg.slot);
					if (q_reg.slot == esrp_pkg::SLOT_STATUS)
					begin
						// Status word carries the alignment pad flag
						q_next.mem_wdata = ctx_rdata |
							(32'(q_reg.align_pad) << esrp_pkg::STATUS_PAD_BIT);
					end
					else
					begin
						q_next.mem_wdata = ctx_rdata;
					end
				end
				else if (mem_ack)
				begin
					q_next.mem_req = 1'b0;
					q_next.mem_we  = 1'b0;
					if (q_reg.slot == q_reg.last_slot)
					begin
						q_next.state = esrp_pkg::ST_IDLE;
						if (q_reg.lazy_op)
						begin
							q_next.lazy_op      = 1'b0;
							q_next.lazy_pending = 1'b0;
							q_next.lazy_done    = 1'b1;
						end
						else
						begin
							q_next.entry_done   = 1'b1;
							q_next.link_wr      = 1'b1;
							q_next.sp_wr        = 1'b1;
							q_next.sp_wdata     = q_reg.base;
							q_next.saved_stack_select_clear  = 1'b1;
							q_next.lazy_pending = q_reg.ext & fp_lazy;
							q_next.lazy_base    = q_reg.base;
						end
					end
					else
					begin
						q_next.slot    = q_reg.slot + 5'h01;
						q_next.ctx_idx = q_reg.slot + 5'h01;
					end
				end
			end
			esrp_pkg::ST_POP:
			begin
				if (!q_reg.mem_req)
				begin
					q_next.mem_req  = 1'b1;
					q_next.mem_we   = 1'b0;
					q_next.mem_addr = slot_addr(q_reg.base, q_reg.slot);
				end
				else if (mem_ack)
				begin
					q_next.mem_req   = 1'b0;
					q_next.ctx_wr    = 1'b1;
					q_next.ctx_idx   = q_reg.slot;
					q_next.align_pad = pad_now;
					if (q_reg.slot == esrp_pkg::SLOT_STATUS)
					begin
						// Pad flag is ours, not part of the restored status
						q_next.ctx_wdata = mem_rdata &
							~(32'h00000001 << esrp_pkg::STATUS_PAD_BIT);
					end
					else
					begin
						q_next.ctx_wdata = mem_rdata;
					end
					if (q_reg.slot == q_reg.last_slot)
					begin
						q_next.state            = esrp_pkg::ST_IDLE;
						q_next.return_done      = 1'b1;
						q_next.sp_wr            = 1'b1;
						q_next.sp_wdata         = q_reg.base + frame_bytes(q_reg.ext) +
							(pad_now ? esrp_pkg::PAD_BYTES : 32'h00000000);
						q_next.saved_stack_select_restore_wr = 1'b1;
						q_next.saved_saved_stack_select      = q_reg.ret_saved_stack_select;
						q_next.lazy_pending     = 1'b0;
					end
					else
					begin
						q_next.slot = q_reg.slot + 5'h01;
					end
				end
			end
			default:
			begin
				q_next.state   = esrp_pkg::ST_IDLE;
				q_next.mem_req = 1'b0;
			end
		endcase

		// Write address and data may come in either order
		if (s_axi_awvalid && q_reg.awready)
		begin
			q_next.aw_got = 1'b1;
			q_next.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && q_reg.wready)
		begin
			q_next.w_got  = 1'b1;
			q_next.wdata  = s_axi_wdata;
			q_next.wstrb0 = s_axi_wstrb[0];
		end
		if (q_reg.bvalid && s_axi_bready)
		begin
			q_next.bvalid = 1'b0;
		end
		if (q_reg.aw_got && q_reg.w_got && !q_reg.bvalid)
		begin
			q_next.aw_got = 1'b0;
			q_next.w_got  = 1'b0;
			q_next.bvalid = 1'b1;
			if (q_reg.awaddr == esrp_pkg::OFS_CTRL)
			begin
				q_next.bresp = esrp_pkg::RESP_OKAY;
				if (q_reg.wstrb0)
				begin
					q_next.ctrl = q_reg.wdata[1:0];
				end
			end
			else
			begin
				q_next.bresp = esrp_pkg::RESP_SLVERR;
			end
		end
		q_next.awready = !q_next.aw_got && !q_next.bvalid;
		q_next.wready  = !q_next.w_got && !q_next.bvalid;

		// Read channel, one read at a time
		if (q_reg.rvalid && s_axi_rready)
		begin
			q_next.rvalid = 1'b0;
		end
		if (s_axi_arvalid && q_reg.arready)
		begin
			q_next.rvalid = 1'b1;
			q_next.rdata  = read_reg(q_reg, s_axi_araddr);
			q_next.rresp  = reg_mapped(s_axi_araddr) ? esrp_pkg::RESP_OKAY : esrp_pkg::RESP_SLVERR;
		end
		q_next.arready = !q_next.rvalid;

		// Synchronous reset
		if (!aresetn)
		begin
			q_next      = '0;
			q_next.ctrl = esrp_pkg::CTRL_RESET;
		end
	end

	always_ff @(posedge aclk)
	begin
		q_reg <= q_next;
	end

	assign ctx_idx            = q_reg.ctx_idx;
	assign ctx_wr             = q_reg.ctx_wr;
	assign ctx_wdata          = q_reg.ctx_wdata;
	assign sp_wr              = q_reg.sp_wr;
	assign sp_wdata           = q_reg.sp_wdata;
	assign link_register      = q_reg.payload;
	assign link_wr            = q_reg.link_wr;
	assign saved_stack_select_clear        = q_reg.saved_stack_select_clear;
	assign saved_stack_select_restore_wr   = q_reg.saved_stack_select_restore_wr;
	assign saved_stack_select = q_reg.saved_saved_stack_select;
	assign entry_done         = q_reg.entry_done;
	assign return_done        = q_reg.return_done;
	assign return_matched     = q_reg.return_matched;
	assign lazy_done          = q_reg.lazy_done;
	assign mem_req            = q_reg.mem_req;
	assign mem_we             = q_reg.mem_we;
	assign mem_addr           = q_reg.mem_addr;
	assign mem_wdata          = q_reg.mem_wdata;
	assign s_axi_awready      = q_reg.awready;
	assign s_axi_wready       = q_reg.wready;
	assign s_axi_bresp        = q_reg.bresp;
	assign s_axi_bvalid       = q_reg.bvalid;
	assign s_axi_arready      = q_reg.arready;
	assign s_axi_rdata        = q_reg.rdata;
	assign s_axi_rresp        = q_reg.rresp;
	assign s_axi_rvalid       = q_reg.rvalid;

endmodule
`default_nettype wire

/* core/esrp_pkg.sv */
package esrp_pkg;

	// Return payload layout
	localparam logic [7:0]  PAY_PREFIX     = 8'hFF;
	localparam logic [16:0] PAY_PAD_ONES   = 17'h1FFFF;
	localparam int          PAY_PREFIX_HI  = 31;
	localparam int          PAY_PREFIX_LO  = 24;
	localparam int          PAY_SEC_STACK  = 6;
	localparam int          PAY_DEF_CALLEE = 5;
	localparam int          PAY_FRAME_FMT  = 4;
	localparam int          PAY_THREAD     = 3;
	localparam int          PAY_SAVED_STACK_SELECT      = 2;
	localparam int          PAY_DOMAIN     = 0;

	// Frame layout: slots in words from the frame base, frame and pad sizes in bytes
	localparam logic [4:0]  SLOT_FIRST     = 5'h00;
	localparam logic [4:0]  SLOT_STATUS    = 5'h07;
	localparam logic [4:0]  SLOT_FP_FIRST  = 5'h08;
	localparam logic [4:0]  SLOT_FP_STATUS_CONTROL_WORD     = 5'h18;
	localparam logic [31:0] BASIC_BYTES    = 32'h00000020;
	localparam logic [31:0] EXT_BYTES      = 32'h00000068;
	localparam logic [31:0] PAD_BYTES      = 32'h00000004;
	localparam logic [31:0] DWORD_MASK     = 32'hFFFFFFF8;
	localparam int          STATUS_PAD_BIT = 9;

	// Register offsets and fields
	localparam logic [11:0] OFS_CTRL       = 12'h000;
	localparam logic [11:0] OFS_STATUS     = 12'h004;
	localparam logic [11:0] OFS_PAYLOAD    = 12'h008;
	localparam logic [11:0] OFS_FRAME      = 12'h00C;
	localparam int          CTRL_FP_EN     = 0;
	localparam int          CTRL_LAZY      = 1;
	localparam logic [1:0]  CTRL_RESET     = 2'h0;
	localparam logic [1:0]  RESP_OKAY      = 2'h0;
	localparam logic [1:0]  RESP_SLVERR    = 2'h2;

	typedef enum logic [1:0] {ST_IDLE, ST_PUSH, ST_POP} esrp_state_t;

endpackage

/* core/esrp_payload_fmt.sv */
`timescale 1ns/10ps
`default_nettype none
module esrp_payload_fmt #(
	parameter bit SEC_PRESENT = 1'b1
) (
	// Entry context
	input  wire logic        frame_secure,
	input  wire logic        callee_skip,
	input  wire logic        ext_frame,
	input  wire logic        thread_mode,
	input  wire logic        stack_select_control_bit,
	input  wire logic        handler_secure,
	// Branch check
	input  wire logic [31:0] branch_target,
	output logic      [31:0] payload,
	output logic             target_is_payload
);

	always_comb
	begin
		payload = {esrp_pkg::PAY_PREFIX, esrp_pkg::PAY_PAD_ONES, 7'h00};
		payload[esrp_pkg::PAY_SEC_STACK]  = SEC_PRESENT & frame_secure;
		payload[esrp_pkg::PAY_DEF_CALLEE] = ~SEC_PRESENT | ~callee_skip;
		payload[esrp_pkg::PAY_FRAME_FMT]  = ~ext_frame;
		payload[esrp_pkg::PAY_THREAD]     = thread_mode;
		payload[esrp_pkg::PAY_SAVED_STACK_SELECT]      = stack_select_control_bit;
		payload[esrp_pkg::PAY_DOMAIN]     = SEC_PRESENT & handler_secure;
	end

	// Non-executable prefix marks a return request
	assign target_is_payload =
		branch_target[esrp_pkg::PAY_PREFIX_HI:esrp_pkg::PAY_PREFIX_LO] == esrp_pkg::PAY_PREFIX;

endmodule
`default_nettype wire

/* tb/esrp_stack_mem.sv */
`timescale 1ns/10ps
`default_nettype none
module esrp_stack_mem (
	// Clock
	input  wire logic        aclk,
	// Stack memory port
	input  wire logic        mem_req,
	input  wire logic        mem_we,
	input  wire logic [31:0] mem_addr,
	input  wire logic [31:0] mem_wdata,
	output logic             mem_ack,
	output logic      [31:0] mem_rdata
);
	logic [31:0] mem [logic [31:0]];
	int          lag = 0;
	// Random lag per access; read data scrambles while not answering
	always @(posedge aclk)
	begin
		mem_ack <= 1'b0;
		mem_rdata <= ~mem_rdata;
		if (mem_req && mem_ack !== 1'b1)
		begin
			if (lag == 0)
			begin
				mem_ack <= 1'b1;
				lag <= $urandom_range(2, 0);
				if (mem_we)
					mem[mem_addr] = mem_wdata;
				else
					mem_rdata <= mem[mem_addr];
			end
			else
				lag <= lag - 1;
		end
	end
endmodule
`default_nettype wire

/* tb/esrp_stack_ctx_assertions.sv */
`timescale 1ns/10ps
`default_nettype none
module esrp_chk (
	// Clock and reset
	input wire logic        aclk,
	input wire logic        aresetn,
	// Entry context
	input wire logic        entry_req,
	input wire logic        frame_secure,
	input wire logic        callee_skip,
	input wire logic        thread_mode,
	input wire logic        stack_select_control_bit,
	input wire logic        handler_secure,
	input wire logic [31:0] sp_in,
	// Results
	input wire logic        sp_wr,
	input wire logic [31:0] sp_wdata,
	input wire logic [31:0] link_register,
	input wire logic        link_wr,
	input wire logic        entry_done,
	input wire logic        return_done,
	input wire logic        return_matched
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	prefix_ok_a: assert property (link_wr |-> link_register[31:24] == 8'hFF)
		else $error("payload prefix wrong");
	pad_bits_a: assert property (link_wr |-> &link_register[23:7] && !link_register[1])
		else $error("payload padding wrong");
	secure_stack_a: assert property (link_wr |-> link_register[6] == frame_secure)
		else $error("secure stack flag wrong");
	callee_flag_a: assert property (link_wr |-> link_register[5] == !callee_skip)
		else $error("callee stacking flag wrong");
	mode_flag_a: assert property (link_wr |-> link_register[3] == thread_mode)
		else $error("mode flag wrong");
	saved_stack_select_saved_a: assert property (link_wr |-> link_register[2] == stack_select_control_bit)
		else $error("stack select not saved");
	domain_flag_a: assert property (link_wr |-> link_register[0] == handler_secure)
		else $error("domain flag wrong");
	link_entry_a: assert property (link_wr |-> entry_req)
		else $error("link written outside entry");
	frame_align_a: assert property (sp_wr && entry_req |-> sp_wdata[2:0] == 3'h0 && sp_wdata <= sp_in - 32'h20)
		else $error("entry stack pointer misaligned");
	cover property (entry_done);
	cover property (return_done && return_matched);
	cover property (sp_wr && entry_req && sp_in[2]);
endmodule
bind esrp_stack_ctx esrp_chk chk_u (.*);
`default_nettype wire

/* tb/test_exception_stacking_return_payload.sv */
`timescale 1ns/10ps
`default_nettype none
module test_exception_stacking_return_payload;
	logic aclk, aresetn, entry_req, frame_secure, callee_skip, thread_mode, handler_secure;
	logic stack_select_control_bit, return_req, fp_first_insn, ctx_wr, sp_wr, link_wr;
	logic saved_stack_select_clear, saved_stack_select_restore_wr, saved_stack_select, entry_done, return_done;
	logic return_matched, lazy_done, mem_req, mem_we, mem_ack;
	logic [4:0] ctx_idx;
	logic [31:0] branch_target, sp_in, ctx_rdata, ctx_wdata, sp_wdata, link_register;
	logic [31:0] mem_addr, mem_wdata, mem_rdata, s_axi_wdata, s_axi_rdata, lr_seen, sp_seen;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [15:0] salt;
	int n_fail = 0;
	int comparisons = 0;
	int cyc = 0;
	esrp_stack_ctx dut_u (.*);
	esrp_stack_mem mem_u (.*);
	assign ctx_rdata = {salt, 11'h000, ctx_idx};
	function automatic logic [31:0] pat(input logic [4:0] i);
		return {salt, 11'h000, i};
	endfunction
	// Context bits: secure stack, callee skip, thread, stack select, secure domain
	function automatic logic [31:0] pay(input logic [4:0] c, input logic fp);
		return {8'hFF, 17'h1FFFF, c[4], ~c[3], ~fp, c[2], c[1], 1'b0, c[0]};
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("BAD t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic finish_test;
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic axi_wr(input logic [11:0] a, input logic [31:0] d);
		logic aw = 1'b1;
		logic w = 1'b1;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (aw || w)
		begin
			@(posedge aclk);
			if (aw && s_axi_awready)
			begin
				aw = 1'b0;
				s_axi_awvalid <= 1'b0;
			end
			if (w && s_axi_wready)
			begin
				w = 1'b0;
				s_axi_wvalid <= 1'b0;
			end
		end
		while (!s_axi_bvalid) @(posedge aclk);
		s_axi_bready <= 1'b0;
		check({30'h0, s_axi_bresp}, 32'h0);
		@(posedge aclk);
	endtask
	task automatic axi_rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		@(posedge aclk);
		while (!s_axi_arready) @(posedge aclk);
		s_axi_arvalid <= 1'b0;
		while (!s_axi_rvalid) @(posedge aclk);
		s_axi_rready <= 1'b0;
		check({30'h0, s_axi_rresp}, {30'h0, r});
		if (r == 2'h0) check(s_axi_rdata, d);
		@(posedge aclk);
	endtask
	task automatic run_frame(input logic [4:0] c, input logic [31:0] sp, input logic fp);
		logic [31:0] base;
		base = (sp - (fp ? esrp_pkg::EXT_BYTES : esrp_pkg::BASIC_BYTES)) & esrp_pkg::DWORD_MASK;
		salt <= 16'($urandom);
		{frame_secure, callee_skip, thread_mode, stack_select_control_bit, handler_secure} <= c;
		sp_in <= sp;
		entry_req <= 1'b1;
		@(posedge aclk);
		while (!entry_done) @(posedge aclk);
		entry_req <= 1'b0;
		@(posedge aclk);
		check(lr_seen, pay(c, fp));
		check(sp_seen, base);
		for (int i = 0; i < 7; i++)
			check(mem_u.mem[base + 32'(4 * i)], pat(5'(i)));
		axi_rd(12'h008, pay(c, fp), 2'h0);
		sp_in <= base;
		branch_target <= pay(c, fp);
		return_req <= 1'b1;
		@(posedge aclk);
		while (!return_done) @(posedge aclk);
		return_req <= 1'b0;
		check({31'h0, return_matched}, 32'h1);
		@(posedge aclk);
		check(sp_seen, sp);
	endtask
	always @(posedge aclk)
	begin
		cyc <= cyc + 1;
		if (link_wr) lr_seen <= link_register;
		if (sp_wr) sp_seen <= sp_wdata;
		if (return_req && ctx_wr && ctx_idx < 5'h07) check(ctx_wdata, pat(ctx_idx));
		if (cyc == 20000)
		begin
			n_fail++;
			finish_test;
		end
	end
	initial
	begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end
	initial
	begin
		void'($urandom(16));
		aresetn = 1'b0;
		salt = 16'h0;
		{entry_req, frame_secure, callee_skip, thread_mode, handler_secure, return_req} = '0;
		{stack_select_control_bit, fp_first_insn, branch_target, sp_in} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		s_axi_wstrb = 4'hF;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		axi_rd(12'h000, 32'h0, 2'h0);
		axi_wr(12'h000, 32'h0);
		axi_rd(12'hFF0, 32'h0, esrp_pkg::RESP_SLVERR);
		for (int k = 0; k < 10; k++)
			run_frame(5'($urandom), k < 2 ? 32'h20002000 + 32'(4 * k) :
				32'h20001000 + 32'($urandom_range(255) * 4), 1'b0);
		axi_wr(12'h000, 32'h00000001);
		run_frame(5'h15, 32'h20003004, 1'b1);
		finish_test;
	end
endmodule
`default_nettype wire
